// File: hdl/acc_pkg.sv
// package: constants and types of the calibration corrector
// How it works
// - calibration record is eight 16-bit words at even offsets 0x00..0x0E
// - temperature readings at offsets 0x0E/0x0C high, 0x08/0x06 low reference
// - reference factor means measured over nominal voltage, times two to fifteen
// - reference correction multiplies raw result by factor, divides by two to fifteen
// - high reference uses factor at 0x0A, low reference uses 0x04
// - offset word at 0x02 is signed and added to the result
// - gain word at 0x00 scales raw result, then divided by two to fifteen
// - with both corrections, gain first, then offset added
// - divide by doubling raw, 32-bit unsigned product, take upper word
// - segment checksum sits at 0x10C0/0x10C1, covers 0x10C2..0x10FF
// - XOR 31 data words, add checksum word, valid when sum is zero
// - on checksum failure no calibration is applied and failure reported
// - calibration record found by tag 0x08, walked by adding lengths
// - length byte follows tag byte; next tag after that many bytes
package acc_pkg;
  localparam logic [15:0] ACC_SEG_BASE    = 16'h10C0;
  localparam logic [15:0] ACC_SEG_LAST    = 16'h10FF;
  localparam logic [15:0] ACC_FIRST_TAG   = 16'h10C2;
  localparam int          ACC_SEG_WORDS   = 32;
  localparam int          ACC_DATA_WORDS  = 31;
  localparam logic [7:0]  ACC_CAL_TAG     = 8'h08;
  localparam logic [3:0]  ACC_OFS_GAIN    = 4'h0;
  localparam logic [3:0]  ACC_OFS_OFFSET  = 4'h2;
  localparam logic [3:0]  ACC_OFS_LO_REF  = 4'h4;
  localparam logic [3:0]  ACC_OFS_LO_T30  = 4'h6;
  localparam logic [3:0]  ACC_OFS_LO_T85  = 4'h8;
  localparam logic [3:0]  ACC_OFS_HI_REF  = 4'hA;
  localparam logic [3:0]  ACC_OFS_HI_T30  = 4'hC;
  localparam logic [3:0]  ACC_OFS_HI_T85  = 4'hE;
  localparam int          ACC_CAL_WORDS   = 8;
  typedef enum logic [5:0] {
    ACC_ST_IDLE  = 6'b000001,
    ACC_ST_SUM   = 6'b000010,
    ACC_ST_WALK  = 6'b000100,
    ACC_ST_LOAD  = 6'b001000,
    ACC_ST_READY = 6'b010000,
    ACC_ST_FAIL  = 6'b100000
  } acc_state_e;
  typedef enum logic [2:0] {
    ACC_CS_IDLE = 3'b001,
    ACC_CS_MUL  = 3'b010,
    ACC_CS_OUT  = 3'b100
  } acc_cstate_e;
endpackage

// File: hdl/acc_mul.sv
// unsigned 16x16 multiply returning the upper product word, registered
`timescale 1ns/1ns
module acc_mul
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  // operands
  input  wire logic [15:0] i_raw,
  input  wire logic [15:0] i_factor,
  // result
  output logic      [15:0] o_product_upper_word
);
  typedef struct packed {
    logic [15:0] upper;
  } acc_mul_s;
  acc_mul_s    st_r;
  acc_mul_s    st_nxt;
  logic [31:0] prod;

  always_comb begin
    // doubled operand then the upper word equals product over two to fifteen
    prod         = {i_raw[14:0], 1'b0} * i_factor;
    st_nxt       = st_r;
    st_nxt.upper = prod[31:16];
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_product_upper_word = st_r.upper;

  chk_upper_word: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_product_upper_word == 16'((32'({$past(i_raw[14:0]), 1'b0}) * 32'($past(i_factor))) >> 16))
    else $error("product upper word mismatch");
endmodule

// File: hdl/acc_top.sv
// calibration corrector: segment check, record walk and result correction
`timescale 1ns/1ns
module acc_top
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  // segment read port, one-cycle read latency
  input  wire logic        i_seg_load,
  output logic             o_seg_rd,
  output logic      [15:0] o_seg_addr,
  input  wire logic [15:0] i_seg_word,
  // segment status
  output logic             o_seg_busy,
  output logic             o_seg_valid,
  output logic             o_seg_fail,
  output logic             o_tag_missing,
  // temperature readings
  output logic      [15:0] o_temp_hi_ref_85c,
  output logic      [15:0] o_temp_hi_ref_30c,
  output logic      [15:0] o_temp_lo_ref_85c,
  output logic      [15:0] o_temp_lo_ref_30c,
  // correction request
  input  wire logic        i_start,
  input  wire logic [15:0] i_raw,
  input  wire logic        i_ref_mode,
  input  wire logic        i_ref_level_select,
  input  wire logic        i_gain_en,
  input  wire logic        i_offset_en,
  // correction answer
  output logic             o_busy,
  output logic             o_done,
  output logic      [15:0] o_result,
  output logic             o_cal_applied
);
  typedef struct packed {
    acc_state_e          st;
    logic [4:0]          idx;
    logic                pend;
    logic [15:0]         sum;
    logic [15:0]         csum;
    logic [15:0]         tag;
    logic [3:0]          cidx;
    logic                rd;
    logic [15:0]         addr;
    logic [8*16-1:0]     cal;
    logic                fail;
    logic                missing;
    acc_cstate_e         cs;
    logic [15:0]         res;
    logic                applied;
    logic                done;
  } acc_top_s;

  acc_top_s    st_r;
  acc_top_s    st_nxt;
  logic [15:0] mul_upper;
  logic [15:0] factor;
  logic        usable;

  function automatic logic [15:0] cal_word(input logic [8*16-1:0] c, input logic [3:0] ofs);
    cal_word = c[16*ofs[3:1] +: 16];
  endfunction

  assign usable = (st_r.st == ACC_ST_READY);
  // offset correction needs the raw value through the multiplier with a unit factor
  always_comb begin
    factor = 16'h8000;
    if (usable && i_ref_mode) begin
      factor = i_ref_level_select ? cal_word(st_r.cal, ACC_OFS_HI_REF) : cal_word(st_r.cal, ACC_OFS_LO_REF);
    end else if (usable && i_gain_en) begin
      factor = cal_word(st_r.cal, ACC_OFS_GAIN);
    end
  end

  acc_mul u_mul (
    .i_core_clk           (i_core_clk),
    .i_reset              (i_reset),
    .i_raw                (i_raw),
    .i_factor             (factor),
    .o_product_upper_word (mul_upper)
  );

  always_comb begin
    st_nxt      = st_r;
    st_nxt.rd   = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.pend = st_r.rd;
    unique case (st_r.st)
      ACC_ST_IDLE, ACC_ST_READY, ACC_ST_FAIL: begin
        if (i_seg_load) begin
          st_nxt.st      = ACC_ST_SUM;
          st_nxt.idx     = 5'h0;
          st_nxt.sum     = 16'h0000;
          st_nxt.addr    = ACC_SEG_BASE;
          st_nxt.rd      = 1'b1;
          st_nxt.fail    = 1'b0;
          st_nxt.missing = 1'b0;
        end
      end
      ACC_ST_SUM: begin
        if (st_r.pend) begin
          if (st_r.addr == ACC_SEG_BASE) begin
            st_nxt.csum = i_seg_word;
          end else begin
            st_nxt.sum = st_r.sum ^ i_seg_word;
          end
          if (st_r.idx == 5'(ACC_DATA_WORDS)) begin
            if (16'(st_r.sum ^ i_seg_word) + st_r.csum != 16'h0000) begin
              st_nxt.st   = ACC_ST_FAIL;
              st_nxt.fail = 1'b1;
            end else begin
              st_nxt.st   = ACC_ST_WALK;
              st_nxt.addr = ACC_FIRST_TAG;
              st_nxt.rd   = 1'b1;
            end
          end else begin
            st_nxt.idx  = st_r.idx + 5'h1;
            st_nxt.addr = st_r.addr + 16'h0002;
            st_nxt.rd   = 1'b1;
          end
        end
      end
      ACC_ST_WALK: begin
        if (st_r.pend) begin
          // words are little endian: tag in low byte, length in high byte
          if (i_seg_word[7:0] == ACC_CAL_TAG) begin
            st_nxt.st   = ACC_ST_LOAD;
            st_nxt.tag  = st_r.addr;
            st_nxt.cidx = 4'h0;
            st_nxt.addr = st_r.addr + 16'h0002;
            st_nxt.rd   = 1'b1;
          end else if (i_seg_word[15:8] == 8'h00 ||
                       17'(st_r.addr) + 17'd2 + 17'(i_seg_word[15:8]) > 17'(ACC_SEG_LAST)) begin
            // an unfound record leaves the segment unusable for correction
            st_nxt.st      = ACC_ST_FAIL;
            st_nxt.missing = 1'b1;
          end else begin
            st_nxt.addr = st_r.addr + 16'h0002 + {8'h00, i_seg_word[15:8]};
            st_nxt.rd   = 1'b1;
          end
        end
      end
      ACC_ST_LOAD: begin
        if (st_r.pend) begin
          st_nxt.cal[16*st_r.cidx[2:0] +: 16] = i_seg_word;
          if (st_r.cidx == 4'(ACC_CAL_WORDS - 1)) begin
            st_nxt.st = ACC_ST_READY;
          end else begin
            st_nxt.cidx = st_r.cidx + 4'h1;
            st_nxt.addr = st_r.addr + 16'h0002;
            st_nxt.rd   = 1'b1;
          end
        end
      end
      default: begin
        st_nxt.st = ACC_ST_IDLE;
      end
    endcase
    unique case (st_r.cs)
      ACC_CS_IDLE: begin
        if (i_start) begin
          st_nxt.cs = ACC_CS_MUL;
        end
      end
      ACC_CS_MUL: begin
        st_nxt.cs      = ACC_CS_OUT;
        st_nxt.applied = usable;
        if (usable && !i_ref_mode && i_offset_en) begin
          st_nxt.res = mul_upper + cal_word(st_r.cal, ACC_OFS_OFFSET);
        end else begin
          st_nxt.res = mul_upper;
        end
      end
      ACC_CS_OUT: begin
        st_nxt.cs   = ACC_CS_IDLE;
        st_nxt.done = 1'b1;
      end
      default: begin
        st_nxt.cs = ACC_CS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r    <= '0;
      st_r.st <= ACC_ST_IDLE;
      st_r.cs <= ACC_CS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_seg_rd          = st_r.rd;
  assign o_seg_addr        = st_r.addr;
  assign o_seg_busy        = !(st_r.st inside {ACC_ST_IDLE, ACC_ST_READY, ACC_ST_FAIL});
  assign o_seg_valid       = usable;
  assign o_seg_fail        = st_r.fail;
  assign o_tag_missing     = st_r.missing;
  assign o_temp_hi_ref_85c = usable ? cal_word(st_r.cal, ACC_OFS_HI_T85) : 16'h0000;
  assign o_temp_hi_ref_30c = usable ? cal_word(st_r.cal, ACC_OFS_HI_T30) : 16'h0000;
  assign o_temp_lo_ref_85c = usable ? cal_word(st_r.cal, ACC_OFS_LO_T85) : 16'h0000;
  assign o_temp_lo_ref_30c = usable ? cal_word(st_r.cal, ACC_OFS_LO_T30) : 16'h0000;
  assign o_busy            = (st_r.cs != ACC_CS_IDLE);
  assign o_done            = st_r.done;
  assign o_result          = st_r.res;
  assign o_cal_applied     = st_r.applied;

  sequence s_req;
    st_r.cs == ACC_CS_IDLE && i_start;
  endsequence
  sequence s_answer;
    ##3 o_done;
  endsequence

  chk_done_timing: assert property (@(posedge i_core_clk) disable iff (i_reset) s_req |-> s_answer)
    else $error("done not three cycles after start");
  chk_done_pulse: assert property (@(posedge i_core_clk) disable iff (i_reset) o_done |=> !o_done)
    else $error("done longer than one cycle");
  chk_result_load: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_done |-> $stable(o_result) && $past(st_r.cs) == ACC_CS_OUT)
    else $error("result changed with done");
  chk_fail_noapply: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_done && o_seg_fail |-> !o_cal_applied)
    else $error("calibration applied after checksum failure");
  chk_valid_excl: assert property (@(posedge i_core_clk) disable iff (i_reset) !(o_seg_valid && o_seg_fail))
    else $error("valid and fail together");
  chk_fail_temp: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !o_seg_valid |-> o_temp_hi_ref_85c == 16'h0000)
    else $error("temperature shown from unusable segment");
  chk_walk_start: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(st_r.st == ACC_ST_WALK) |-> o_seg_addr == ACC_FIRST_TAG && o_seg_rd)
    else $error("walk did not start at first tag");
  chk_ref_result: assert property (@(posedge i_core_clk) disable iff (i_reset)
    s_req ##1 (usable && i_ref_mode) |=> o_result == $past(mul_upper))
    else $error("reference correction result wrong");
  chk_load_order: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(st_r.st == ACC_ST_LOAD) |-> o_seg_addr == st_r.tag + 16'h0002)
    else $error("record load not at tag plus two");
endmodule

// File: test/acc_seg_model.sv
// calibration segment memory with one-cycle read latency
`timescale 1ns/1ns
module acc_seg_model (
  // clock
  input  wire logic        i_core_clk,
  // read port
  input  wire logic        i_seg_rd,
  input  wire logic [15:0] i_seg_addr,
  output logic      [15:0] o_seg_word
);
  // 32 words covering 0x10C0..0x10FE, loaded by the bench
  logic [15:0] mem [32];
  initial o_seg_word = 16'h0000;
  // data valid only the cycle after a read; otherwise it toggles so stale data looks right only every other cycle
  always @(posedge i_core_clk) begin
    if (i_seg_rd) begin
      o_seg_word <= mem[i_seg_addr[5:1]];
    end else begin
      o_seg_word <= ~o_seg_word;
    end
  end
endmodule

// File: test/tb_top.sv
// self-checking bench for the calibration corrector
`timescale 1ns/1ns
module tb_top;
  import acc_pkg::*;
  logic        i_core_clk, i_reset, i_seg_load, i_start, i_ref_mode;
  logic        i_ref_level_select, i_gain_en, i_offset_en;
  logic [15:0] i_raw, i_seg_word, o_seg_addr, o_result;
  logic [15:0] o_temp_hi_ref_85c, o_temp_hi_ref_30c, o_temp_lo_ref_85c, o_temp_lo_ref_30c;
  logic        o_seg_rd, o_seg_busy, o_seg_valid, o_seg_fail, o_tag_missing;
  logic        o_busy, o_done, o_cal_applied;
  int          failures, num_checks;
  // gain, offset, lo factor, lo 30c, lo 85c, hi factor, hi 30c, hi 85c
  logic [15:0] cal [8] = '{16'h8010, 16'hFFFE, 16'h7BBB, 16'h0A11, 16'h0B22, 16'h8123, 16'h0C33, 16'h0D44};
  logic [15:0] gx [4] = '{16'h0800, 16'h07FE, 16'h0801, 16'h07FF};

  acc_top acc_top_inst (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_seg_load(i_seg_load),
    .o_seg_rd(o_seg_rd), .o_seg_addr(o_seg_addr), .i_seg_word(i_seg_word), .o_seg_busy(o_seg_busy),
    .o_seg_valid(o_seg_valid), .o_seg_fail(o_seg_fail), .o_tag_missing(o_tag_missing),
    .o_temp_hi_ref_85c(o_temp_hi_ref_85c), .o_temp_hi_ref_30c(o_temp_hi_ref_30c),
    .o_temp_lo_ref_85c(o_temp_lo_ref_85c), .o_temp_lo_ref_30c(o_temp_lo_ref_30c),
    .i_start(i_start), .i_raw(i_raw), .i_ref_mode(i_ref_mode), .i_ref_level_select(i_ref_level_select),
    .i_gain_en(i_gain_en), .i_offset_en(i_offset_en), .o_busy(o_busy), .o_done(o_done),
    .o_result(o_result), .o_cal_applied(o_cal_applied));
  acc_seg_model acc_seg_model_inst (.i_core_clk(i_core_clk), .i_seg_rd(o_seg_rd),
    .i_seg_addr(o_seg_addr), .o_seg_word(i_seg_word));

  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end

  task automatic end_sim();
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // doubled raw times factor, upper product word
  function automatic logic [15:0] mulhi(input logic [15:0] raw, input logic [15:0] f);
    logic [31:0] p;
    p = {raw[14:0], 1'b0} * f;
    return p[31:16];
  endfunction

  // segment image: empty record at 0x10C2, calibration record at 0x10DA unless tag spoilt
  task automatic build(input logic good);
    logic [15:0] x;
    x = 16'h0000;
    for (int i = 0; i < 32; i++) acc_seg_model_inst.mem[i] = 16'hFFFF;
    acc_seg_model_inst.mem[1] = 16'h16FE;
    acc_seg_model_inst.mem[13] = good ? 16'h1008 : 16'h10FE;
    for (int i = 0; i < 8; i++) acc_seg_model_inst.mem[14 + i] = cal[i];
    for (int i = 1; i < 32; i++) x = x ^ acc_seg_model_inst.mem[i];
    acc_seg_model_inst.mem[0] = -x;
  endtask

  task automatic load();
    int n;
    n = 0;
    @(negedge i_core_clk) i_seg_load = 1'b1;
    @(negedge i_core_clk) i_seg_load = 1'b0;
    chk("seg_busy", 16'h0001, {15'h0, o_seg_busy});
    while (o_seg_busy === 1'b1 && n < 400) begin
      @(negedge i_core_clk);
      n++;
    end
    chk("seg_busy_end", 16'h0000, {15'h0, o_seg_busy});
  endtask

  // start held through busy cycles, which must be ignored; done stands between the third and fourth edges
  task automatic correct(input logic [15:0] raw, input logic rm, rs, ge, oe,
                         input logic [15:0] exp, input logic app);
    @(negedge i_core_clk);
    chk("busy_idle", 16'h0000, {15'h0, o_busy});
    chk("done_low", 16'h0000, {15'h0, o_done});
    i_raw = raw;
    i_ref_mode = rm;
    i_ref_level_select = rs;
    i_gain_en = ge;
    i_offset_en = oe;
    i_start = 1'b1;
    @(negedge i_core_clk);
    chk("busy", 16'h0001, {15'h0, o_busy});
    repeat (2) @(negedge i_core_clk);
    i_start = 1'b0;
    chk("done", 16'h0001, {15'h0, o_done});
    chk("result", exp, o_result);
    chk("cal_applied", {15'h0, app}, {15'h0, o_cal_applied});
  endtask

  initial begin
    failures = 0;
    num_checks = 0;
    {i_seg_load, i_start, i_ref_mode, i_ref_level_select, i_gain_en, i_offset_en} = '0;
    i_raw = 16'h0000;
    i_reset = 1'b1;
    repeat (3) @(posedge i_core_clk);
    @(negedge i_core_clk) i_reset = 1'b0;
    correct(16'h0100, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0100, 1'b0);
    build(1'b1);
    acc_seg_model_inst.mem[0] ^= 16'h0001;
    load();
    chk("seg_fail", 16'h0001, {15'h0, o_seg_fail});
    chk("seg_valid", 16'h0000, {15'h0, o_seg_valid});
    correct(16'h0800, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0800, 1'b0);
    build(1'b1);
    load();
    chk("seg_valid", 16'h0001, {15'h0, o_seg_valid});
    chk("temp_hi_85", cal[7], o_temp_hi_ref_85c);
    chk("temp_hi_30", cal[6], o_temp_hi_ref_30c);
    chk("temp_lo_85", cal[4], o_temp_lo_ref_85c);
    chk("temp_lo_30", cal[3], o_temp_lo_ref_30c);
    correct(16'h0100, 1'b1, 1'b0, 1'b1, 1'b1, 16'h00F7, 1'b1);
    correct(16'h0100, 1'b1, 1'b1, 1'b0, 1'b0, mulhi(16'h0100, cal[5]), 1'b1);
    correct(16'h8FFF, 1'b1, 1'b0, 1'b0, 1'b0, mulhi(16'h8FFF, cal[2]), 1'b1);
    for (int k = 0; k < 4; k++) begin
      correct(16'h0800, 1'b0, 1'b0, k[1], k[0], gx[k], 1'b1);
    end
    correct(16'h0001, 1'b0, 1'b0, 1'b0, 1'b1, 16'hFFFF, 1'b1);
    build(1'b0);
    load();
    chk("tag_missing", 16'h0001, {15'h0, o_tag_missing});
    chk("temp_zero", 16'h0000, o_temp_hi_ref_85c);
    correct(16'h0800, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0800, 1'b0);
    end_sim();
  end

  // whole run is about 300 cycles
  initial begin
    #(50 * 20000);
    failures++;
    end_sim();
  end
endmodule
